// ---- usb_host_ep_pkg.sv ----
// constants and types for the host endpoint transaction block
// Behaviour
// (R1) software resets controller before host/device mode change
// (R2) full/low-speed targets, hub split handled internally
// (R3) IN uses receive side, OUT transmit side
// (R4) software sizes FIFOs: 64 bytes, iso 1023
// (R5) control pair plus three IN, three OUT
// (R6) control interface: endpoint zero, lowest 64 FIFO bytes
// (R7) IN and OUT halves target independently
// (R8) software programs target addresses before any access
// (R9) programmable FIFO base and size per transfer
// (R10) IN token only after request flag set
// (R11) stored packet sets receive ready, receive interrupt
// (R12) clearing receive ready sends acknowledge to target; two interfaces cleared in one cycle get one, for the higher
// (R13) auto-clear after maximum-sized packet read out
// (R14) auto-request re-sets request on receive-ready clear
// (R15) request count decrements; zero clears auto-request
// (R16) zero count: short packet clears auto-request
// (R17) IN NAK retried until NAK limit
// (R18) IN STALL: no retry, set stall flag
// (R19) IN errors retried; third failure sets error
// (R20) transmit ready set per packet or auto-set
// (R21) OUT NAK retried; STALL sets flag, interrupt
// (R22) OUT errors retried; third failure flushes, error
package usb_host_ep_pkg;
  localparam logic [1:0] RES_DATA = 2'h0;
  localparam logic [1:0] RES_NAK = 2'h1;
  localparam logic [1:0] RES_STALL = 2'h2;
  localparam logic [1:0] RES_ERR = 2'h3;
  // three attempts: failures numbered 0,1,2
  localparam logic [1:0] LAST_TRY = 2'h2;
  localparam logic [11:0] CTRL_FIFO_BASE = 12'h000;
  localparam logic [11:0] CTRL_FIFO_SIZE = 12'h040;
  localparam logic [1:0] TYPE_CONTROL = 2'h0;
  localparam logic [3:0] CTRL_EP_NUM = 4'h0;
  localparam logic [1:0] CTRL_IF = 2'h0;
  localparam logic [1:0] BUF_FULL = 2'h2;
  localparam logic [15:0] CNT_LAST = 16'h0001;
  typedef enum logic [1:0] {
    ST_SCAN = 2'b01,
    ST_WAIT = 2'b10
  } sched_t;
endpackage

// ---- usb_host_ep_core.sv ----
// host endpoint transaction scheduler, handshakes and receive buffer
`timescale 1ns/1ps
`default_nettype none
module usb_host_ep_core (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:0] sw_req_set,
  input wire logic [3:0] sw_rx_clr,
  input wire logic [3:0] sw_tx_set,
  input wire logic [3:0] sw_areq_set,
  input wire logic [3:0] sw_areq_clr,
  input wire logic [3:0] sw_stat_clr,
  input wire logic [3:0] cnt_load,
  input wire logic [15:0] cnt_value,
  input wire logic [3:0] auto_clear_rx,
  input wire logic [3:0] auto_set_tx,
  input wire logic [3:0][10:0] max_payload,
  input wire logic [3:0][10:0] tx_max_payload,
  input wire logic [3:0][7:0] rx_nak_limit,
  input wire logic [3:0][7:0] tx_nak_limit,
  input wire logic [3:0][6:0] rx_target_address,
  input wire logic [3:0][6:0] tx_target_address,
  input wire logic [3:0][3:0] rx_target_ep,
  input wire logic [3:0][3:0] tx_target_ep,
  input wire logic [3:0][1:0] rx_type,
  input wire logic [3:0][1:0] tx_type,
  input wire logic [3:0] rx_via_hub,
  input wire logic [3:0] tx_via_hub,
  input wire logic [3:0][11:0] rx_fifo_base,
  input wire logic [3:0][11:0] rx_fifo_size,
  input wire logic [3:0][11:0] tx_fifo_base,
  input wire logic [3:0][11:0] tx_fifo_size,
  input wire logic tx_load_valid,
  input wire logic [1:0] tx_load_if,
  input wire logic res_valid,
  input wire logic [1:0] res_code,
  input wire logic [10:0] res_len,
  input wire logic rx_in_valid,
  input wire logic [7:0] rx_in_data,
  output logic rx_in_ready,
  output logic rd_valid,
  output logic [7:0] rd_data,
  input wire logic rd_ready,
  output logic tok_valid,
  output logic tok_in,
  output logic [1:0] tok_if,
  output logic [6:0] tok_addr,
  output logic [3:0] tok_ep,
  output logic [1:0] tok_type,
  output logic tok_split,
  output logic [11:0] tok_fifo_base,
  output logic [11:0] tok_fifo_size,
  output logic ack_valid,
  output logic [1:0] ack_if,
  output logic [3:0] request_packet_flag,
  output logic [3:0] receive_packet_ready,
  output logic [3:0] auto_request,
  output logic [3:0] rx_stalled,
  output logic [3:0] rx_error,
  output logic [3:0] rx_nak_timeout,
  output logic [3:0] transmit_packet_ready,
  output logic [3:0] tx_stalled,
  output logic [3:0] tx_error,
  output logic [3:0] tx_nak_timeout,
  output logic [3:0] rx_irq,
  output logic [3:0] tx_irq,
  output logic [3:0] tx_flush
);

  typedef struct packed {
    usb_host_ep_pkg::sched_t st;
    logic [2:0] ptr;
    logic [3:0] req, rxr, areq, rstall, rerr, rnak;
    logic [3:0] txr, tstall, terr, tnak;
    logic [3:0][15:0] rcnt;
    logic [3:0][1:0] rtry, ttry;
    logic [3:0][7:0] rnk, tnk;
    logic [3:0][10:0] tld;
    logic [10:0] rdn;
    logic [1:0] uep;
    logic tv, ti, av;
    logic [1:0] tif, aif;
    logic [6:0] ta;
    logic [3:0] te;
    logic [1:0] tt;
    logic tsp;
    logic [11:0] tfb, tfs;
    logic [3:0] rirq, tirq, tfl;
    logic [1:0][7:0] bd;
    logic [1:0] bc;
    logic vld, irdy;
  } core_t;

  core_t s, next_s;
  logic [1:0] cur;
  logic cur_in;
  assign cur = s.ptr[1:0];
  // slots 0..3 receive side, 4..7 transmit side of the same interfaces
  assign cur_in = ~s.ptr[2]; // [R3] [R5]

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [1:0] c;
    logic pop;
    logic push;
    c = s.bc;
    pop = s.vld & rd_ready;
    push = rx_in_valid & s.irdy;
    next_s = s;
    next_s.tv = 1'b0;
    next_s.av = 1'b0;
    next_s.rirq = 4'h0;
    next_s.tirq = 4'h0;
    next_s.tfl = 4'h0;
    // clears first so a same-cycle hardware set wins
    for (int i = 0; i < 4; i++) begin
      if (sw_stat_clr[i]) begin
        next_s.rstall[i] = 1'b0;
        next_s.rerr[i] = 1'b0;
        next_s.rnak[i] = 1'b0;
        next_s.tstall[i] = 1'b0;
        next_s.terr[i] = 1'b0;
        next_s.tnak[i] = 1'b0;
      end
      if (sw_areq_clr[i]) begin
        next_s.areq[i] = 1'b0;
      end
      if (cnt_load[i]) begin
        next_s.rcnt[i] = cnt_value;
      end
    end

    unique case (s.st)
      usb_host_ep_pkg::ST_SCAN: begin
        if (cur_in ? (s.req[cur] & ~s.rxr[cur]) : s.txr[cur]) begin // [R10]
          next_s.tv = 1'b1;
          next_s.ti = cur_in;
          next_s.tif = cur;
          next_s.ta = cur_in ? rx_target_address[cur] : tx_target_address[cur]; // [R7]
          next_s.te = cur_in ? rx_target_ep[cur] : tx_target_ep[cur];
          next_s.tt = cur_in ? rx_type[cur] : tx_type[cur];
          next_s.tsp = cur_in ? rx_via_hub[cur] : tx_via_hub[cur]; // [R2]
          next_s.tfb = cur_in ? rx_fifo_base[cur] : tx_fifo_base[cur]; // [R9]
          next_s.tfs = cur_in ? rx_fifo_size[cur] : tx_fifo_size[cur];
          if (cur == usb_host_ep_pkg::CTRL_IF) begin // [R6]
            next_s.te = usb_host_ep_pkg::CTRL_EP_NUM;
            next_s.tt = usb_host_ep_pkg::TYPE_CONTROL;
            next_s.tfb = usb_host_ep_pkg::CTRL_FIFO_BASE;
            next_s.tfs = usb_host_ep_pkg::CTRL_FIFO_SIZE;
          end
          if (cur_in && s.rcnt[cur] != 16'h0000) begin // [R15]
            next_s.rcnt[cur] = s.rcnt[cur] - 16'h0001;
            if (s.rcnt[cur] == usb_host_ep_pkg::CNT_LAST) begin
              next_s.areq[cur] = 1'b0;
            end
          end
          next_s.st = usb_host_ep_pkg::ST_WAIT;
        end else begin
          next_s.ptr = s.ptr + 3'h1;
        end
      end
      usb_host_ep_pkg::ST_WAIT: begin
        if (res_valid) begin
          // retries go to the back of the scan so NAKs cannot hog the bus
          next_s.ptr = s.ptr + 3'h1;
          next_s.st = usb_host_ep_pkg::ST_SCAN;
          if (cur_in) begin
            unique case (res_code)
              usb_host_ep_pkg::RES_DATA: begin
                next_s.req[cur] = 1'b0;
                next_s.rxr[cur] = 1'b1; // [R11]
                next_s.rirq[cur] = 1'b1;
                next_s.uep = cur;
                next_s.rdn = res_len - 11'(s.bc); // bytes streamed out before the result count too
                next_s.rtry[cur] = 2'h0;
                next_s.rnk[cur] = 8'h00;
                if (res_len < max_payload[cur] && s.rcnt[cur] == 16'h0000) begin
                  next_s.areq[cur] = 1'b0; // [R16]
                end
              end
              usb_host_ep_pkg::RES_NAK: begin // [R17]
                next_s.rnk[cur] = s.rnk[cur] + 8'h01;
                if (rx_nak_limit[cur] != 8'h00 && next_s.rnk[cur] == rx_nak_limit[cur]) begin
                  next_s.req[cur] = 1'b0;
                  next_s.rnak[cur] = 1'b1;
                  next_s.rnk[cur] = 8'h00;
                  next_s.rirq[cur] = 1'b1;
                end
              end
              usb_host_ep_pkg::RES_STALL: begin // [R18]
                next_s.req[cur] = 1'b0;
                next_s.rstall[cur] = 1'b1;
                next_s.rirq[cur] = 1'b1;
              end
              usb_host_ep_pkg::RES_ERR: begin // [R19]
                next_s.rtry[cur] = s.rtry[cur] + 2'h1;
                if (s.rtry[cur] == usb_host_ep_pkg::LAST_TRY) begin
                  next_s.req[cur] = 1'b0;
                  next_s.rerr[cur] = 1'b1;
                  next_s.rtry[cur] = 2'h0;
                  next_s.rirq[cur] = 1'b1;
                end
              end
            endcase
          end else begin
            unique case (res_code)
              usb_host_ep_pkg::RES_DATA: begin
                next_s.txr[cur] = 1'b0;
                next_s.tirq[cur] = 1'b1;
                next_s.ttry[cur] = 2'h0;
                next_s.tnk[cur] = 8'h00;
              end
              usb_host_ep_pkg::RES_NAK: begin // [R21]
                next_s.tnk[cur] = s.tnk[cur] + 8'h01;
                if (tx_nak_limit[cur] != 8'h00 && next_s.tnk[cur] == tx_nak_limit[cur]) begin
                  next_s.txr[cur] = 1'b0;
                  next_s.tnak[cur] = 1'b1;
                  next_s.tnk[cur] = 8'h00;
                  next_s.tirq[cur] = 1'b1;
                end
              end
              usb_host_ep_pkg::RES_STALL: begin // [R21]
                next_s.txr[cur] = 1'b0;
                next_s.tstall[cur] = 1'b1;
                next_s.tirq[cur] = 1'b1;
              end
              usb_host_ep_pkg::RES_ERR: begin // [R22]
                next_s.ttry[cur] = s.ttry[cur] + 2'h1;
                if (s.ttry[cur] == usb_host_ep_pkg::LAST_TRY) begin
                  next_s.txr[cur] = 1'b0;
                  next_s.terr[cur] = 1'b1;
                  next_s.tfl[cur] = 1'b1;
                  next_s.ttry[cur] = 2'h0;
                  next_s.tld[cur] = 11'h000;
                  next_s.tirq[cur] = 1'b1;
                end
              end
            endcase
          end
        end
      end
    endcase

    // software sets come last so they survive a hardware clear
    for (int i = 0; i < 4; i++) begin
      if (sw_req_set[i]) begin
        next_s.req[i] = 1'b1;
      end
      if (sw_areq_set[i]) begin
        next_s.areq[i] = 1'b1;
      end
      if (sw_tx_set[i]) begin // [R20]
        next_s.txr[i] = 1'b1;
        next_s.tld[i] = 11'h000;
      end
    end
    if (tx_load_valid) begin
      next_s.tld[tx_load_if] = next_s.tld[tx_load_if] + 11'h001;
      if (auto_set_tx[tx_load_if] && next_s.tld[tx_load_if] == tx_max_payload[tx_load_if]) begin
        next_s.txr[tx_load_if] = 1'b1; // [R20]
        next_s.tld[tx_load_if] = 11'h000;
      end
    end

    // unload counting drives auto-clear of the packet being read
    if (pop) begin
      next_s.rdn = next_s.rdn + 11'h001;
    end
    for (int i = 0; i < 4; i++) begin
      if (s.rxr[i] && (sw_rx_clr[i] || (auto_clear_rx[i] && s.uep == i[1:0]
          && s.rdn == max_payload[i]))) begin // [R13]
        next_s.rxr[i] = 1'b0;
        next_s.av = 1'b1; // [R12]
        next_s.aif = i[1:0];
        if (next_s.areq[i]) begin
          next_s.req[i] = 1'b1; // [R14]
        end
      end
    end

    // two-entry buffer; ready is registered so a full buffer stalls the link
    if (pop) begin
      next_s.bd[0] = s.bd[1];
      c = c - 2'h1;
    end
    if (push) begin
      next_s.bd[c[0]] = rx_in_data;
      c = c + 2'h1;
    end
    next_s.bc = c;
    next_s.vld = (c != 2'h0);
    next_s.irdy = (c != usb_host_ep_pkg::BUF_FULL);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.st <= usb_host_ep_pkg::ST_SCAN;
      s.irdy <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  assign rx_in_ready = s.irdy;
  assign rd_valid = s.vld;
  assign rd_data = s.bd[0];
  assign tok_valid = s.tv;
  assign tok_in = s.ti;
  assign tok_if = s.tif;
  assign tok_addr = s.ta;
  assign tok_ep = s.te;
  assign tok_type = s.tt;
  assign tok_split = s.tsp;
  assign tok_fifo_base = s.tfb;
  assign tok_fifo_size = s.tfs;
  assign ack_valid = s.av;
  assign ack_if = s.aif;
  assign request_packet_flag = s.req;
  assign receive_packet_ready = s.rxr;
  assign auto_request = s.areq;
  assign rx_stalled = s.rstall;
  assign rx_error = s.rerr;
  assign rx_nak_timeout = s.rnak;
  assign transmit_packet_ready = s.txr;
  assign tx_stalled = s.tstall;
  assign tx_error = s.terr;
  assign tx_nak_timeout = s.tnak;
  assign rx_irq = s.rirq;
  assign tx_irq = s.tirq;
  assign tx_flush = s.tfl;

  ////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic res_in;
  logic res_out;
  assign res_in = s.st == usb_host_ep_pkg::ST_WAIT && res_valid && cur_in;
  assign res_out = s.st == usb_host_ep_pkg::ST_WAIT && res_valid && !cur_in;

  a_tok_needs_req: assert property (s.tv && s.ti |-> s.tif == cur && $past(s.req[cur]) && !$past(s.rxr[cur])) // [R10]
    else $error("IN token without request");
  a_ctrl_fifo_low: assert property (s.tv && s.tif == usb_host_ep_pkg::CTRL_IF |->
    s.tfb == usb_host_ep_pkg::CTRL_FIFO_BASE && s.tfs == usb_host_ep_pkg::CTRL_FIFO_SIZE) // [R6]
    else $error("control FIFO window wrong");
  a_data_sets_ready: assert property (res_in && res_code == usb_host_ep_pkg::RES_DATA |=>
    s.rxr[$past(cur)] && s.rirq[$past(cur)]) // [R11]
    else $error("received packet not flagged");
  a_clear_sends_ack: assert property (sw_rx_clr[1] && s.rxr[1] |=> s.av && s.aif == 2'h1) // [R12]
    else $error("no acknowledge after clear");
  a_in_stall_stop: assert property (res_in && res_code == usb_host_ep_pkg::RES_STALL && !sw_req_set[cur] |=>
    !s.req[$past(cur)] && s.rstall[$past(cur)] ##1 !(s.tv && s.ti && s.tif == $past(cur, 2))) // [R18]
    else $error("IN stall retried");
  a_in_third_err: assert property (res_in && res_code == usb_host_ep_pkg::RES_ERR && s.rtry[cur] == 2'h2
    && !sw_req_set[cur] |=> s.rerr[$past(cur)] && !s.req[$past(cur)]) // [R19]
    else $error("third IN error not reported");
  a_out_third_err: assert property (res_out && res_code == usb_host_ep_pkg::RES_ERR && s.ttry[cur] == 2'h2 |=>
    s.tfl[$past(cur)] && s.terr[$past(cur)] ##1 s.tfl == 4'h0) // [R22]
    else $error("third OUT error not flushed");
  a_out_stall_irq: assert property (res_out && res_code == usb_host_ep_pkg::RES_STALL |=>
    s.tstall[$past(cur)] && s.tirq[$past(cur)]) // [R21]
    else $error("OUT stall not flagged");
  a_count_end_stop: assert property (s.st == usb_host_ep_pkg::ST_SCAN && cur_in && s.req[cur] && !s.rxr[cur]
    && s.rcnt[cur] == 16'h0001 && !sw_areq_set[cur] |=> !s.areq[$past(cur)]) // [R15]
    else $error("auto-request kept at count end");
  a_buf_no_over: assert property (s.bc == usb_host_ep_pkg::BUF_FULL && !rd_ready |=> s.bd == $past(s.bd) && !s.irdy)
    else $error("buffer overfilled");
endmodule
`default_nettype wire

// ---- usb_target_model.sv ----
// behavioural usb target that answers host tokens
`timescale 1ns/1ps
`default_nettype none
module usb_target_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic tok_valid,
  input wire logic tok_in,
  input wire logic rx_in_ready,
  input wire logic [1:0] reply,
  input wire logic [10:0] reply_len,
  output logic res_valid,
  output logic [1:0] res_code,
  output logic [10:0] res_len,
  output logic rx_in_valid,
  output logic [7:0] rx_in_data
);
  logic [7:0] next_byte;
  logic ok;
  int b;
  initial begin
    res_valid = 1'b0;
    res_code = 2'h0;
    res_len = 11'h000;
    rx_in_valid = 1'b0;
    rx_in_data = 8'h00;
    next_byte = 8'h00;
    forever begin
      @(negedge core_clk);
      if (rstn === 1'b1 && tok_valid === 1'b1) begin
        // slow turnaround, as a real target behind a hub
        repeat (2) @(negedge core_clk);
        if (tok_in === 1'b1 && reply == usb_host_ep_pkg::RES_DATA) begin
          for (b = 0; b < reply_len; b++) begin
            rx_in_valid = 1'b1;
            rx_in_data = next_byte;
            ok = 1'b0;
            while (!ok) begin
              ok = rx_in_ready;
              @(negedge core_clk);
            end
            next_byte++;
          end
          rx_in_valid = 1'b0;
          // released lines must not keep the last byte
          rx_in_data = ~rx_in_data;
        end
        res_valid = 1'b1;
        res_code = reply;
        res_len = reply_len;
        @(negedge core_clk);
        res_valid = 1'b0;
        res_code = ~res_code;
        res_len = ~res_len;
      end
    end
  end
endmodule
`default_nettype wire

// ---- usb_host_endpoint_transactions_test.sv ----
// self-checking bench for the host endpoint transaction block
`timescale 1ns/1ps
`default_nettype none
module usb_host_endpoint_transactions_test;
  logic core_clk, rstn, rd_ready;
  logic [7:0][3:0] strb;
  logic [15:0] cnt_value;
  logic [3:0] auto_clear_rx, auto_set_tx, rx_via_hub, tx_via_hub;
  logic [3:0][10:0] max_payload, tx_max_payload;
  logic [3:0][7:0] rx_nak_limit, tx_nak_limit;
  logic [3:0][6:0] rx_target_address, tx_target_address;
  logic [3:0][3:0] rx_target_ep, tx_target_ep;
  logic [3:0][1:0] rx_type, tx_type;
  logic [3:0][11:0] rx_fifo_base, rx_fifo_size, tx_fifo_base, tx_fifo_size;
  logic res_valid, rx_in_valid, rx_in_ready, rd_valid, tok_valid, tok_in, tok_split, ack_valid;
  logic [1:0] tx_load_if, res_code, tok_if, tok_type, ack_if, reply, ack_snap;
  logic [10:0] res_len, reply_len;
  logic [7:0] rx_in_data, rd_data, exp_byte;
  logic [6:0] tok_addr;
  logic [3:0] tok_ep;
  logic [11:0] tok_fifo_base, tok_fifo_size;
  logic [3:0] request_packet_flag, receive_packet_ready, auto_request, rx_stalled, rx_error, rx_nak_timeout;
  logic [3:0] transmit_packet_ready, tx_stalled, tx_error, tx_nak_timeout, rx_irq, tx_irq, tx_flush;
  logic [16:0] tok_snap;
  logic [23:0] fifo_snap;
  logic [2:0] flags;
  logic [1:0] codes [3];
  int ntok [3];
  int errors, samples_checked, toks, acks, rirqs, tirqs, flushes, d, c, i, t0, r0, f0, a0;

  usb_host_ep_core DUT (.core_clk, .rstn, .sw_req_set(strb[0]), .sw_rx_clr(strb[1]), .sw_tx_set(strb[2]),
    .sw_areq_set(strb[3]), .sw_areq_clr(strb[4]), .sw_stat_clr(strb[5]), .cnt_load(strb[6]), .cnt_value,
    .auto_clear_rx, .auto_set_tx, .max_payload, .tx_max_payload, .rx_nak_limit, .tx_nak_limit,
    .rx_target_address, .tx_target_address, .rx_target_ep, .tx_target_ep, .rx_type, .tx_type,
    .rx_via_hub, .tx_via_hub, .rx_fifo_base, .rx_fifo_size, .tx_fifo_base, .tx_fifo_size,
    .tx_load_valid(strb[7] != 4'h0), .tx_load_if, .res_valid, .res_code, .res_len, .rx_in_valid,
    .rx_in_data, .rx_in_ready, .rd_valid, .rd_data, .rd_ready, .tok_valid, .tok_in, .tok_if, .tok_addr,
    .tok_ep, .tok_type, .tok_split, .tok_fifo_base, .tok_fifo_size, .ack_valid, .ack_if,
    .request_packet_flag, .receive_packet_ready, .auto_request, .rx_stalled, .rx_error, .rx_nak_timeout,
    .transmit_packet_ready, .tx_stalled, .tx_error, .tx_nak_timeout, .rx_irq, .tx_irq, .tx_flush);

  usb_target_model partner (.core_clk, .rstn, .tok_valid, .tok_in, .rx_in_ready, .reply, .reply_len,
    .res_valid, .res_code, .res_len, .rx_in_valid, .rx_in_data);

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task conclude();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one-cycle software strobe; kind 7 loads one tx byte
  task strobe(input int k, input int n);
    @(negedge core_clk);
    strb[k][n] = 1'b1;
    tx_load_if = 2'(n);
    @(negedge core_clk);
    strb = 32'h0;
  endtask

  // nothing schedulable for 12 cycles means the traffic has drained
  task wait_quiet();
    int q, k;
    q = 0;
    for (k = 0; k < 3000 && q < 12; k++) begin
      @(negedge core_clk);
      if ((request_packet_flag & ~receive_packet_ready) === 4'h0 && transmit_packet_ready === 4'h0) q++;
      else q = 0;
    end
    if (q < 12) check("traffic drained", 0, 1);
  endtask

  always @(posedge core_clk) begin
    if (tok_valid === 1'b1) begin
      toks++;
      tok_snap = {tok_in, tok_if, tok_addr, tok_ep, tok_type, tok_split};
      fifo_snap = {tok_fifo_base, tok_fifo_size};
    end
    if (ack_valid === 1'b1) begin
      acks++;
      ack_snap = ack_if;
    end
    rirqs += $countones(rx_irq);
    tirqs += $countones(tx_irq);
    flushes += $countones(tx_flush);
    if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
      check("popped byte", rd_data, exp_byte);
      exp_byte++;
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    repeat (50000) @(posedge core_clk);
    errors++;
    conclude();
  end

  initial begin
    rstn = 1'b0;
    strb = 32'h0;
    tx_load_if = 2'h0;
    cnt_value = 16'h0000;
    auto_clear_rx = 4'h0;
    auto_set_tx = 4'h0;
    rd_ready = 1'b1;
    exp_byte = 8'h00;
    reply = usb_host_ep_pkg::RES_DATA;
    reply_len = 11'h004;
    max_payload = {4{11'h004}};
    tx_max_payload = {4{11'h004}};
    rx_nak_limit = {4{8'h02}};
    tx_nak_limit = {4{8'h02}};
    rx_target_address = {7'h13, 7'h12, 7'h11, 7'h10};
    tx_target_address = {7'h23, 7'h22, 7'h21, 7'h20};
    rx_target_ep = {4'h4, 4'h3, 4'h2, 4'h1};
    tx_target_ep = {4{4'h5}};
    rx_type = {4{2'h2}};
    tx_type = {4{2'h3}};
    rx_via_hub = 4'h2;
    tx_via_hub = 4'h0;
    rx_fifo_base = {12'h400, 12'h300, 12'h200, 12'h100};
    rx_fifo_size = {4{12'h080}};
    tx_fifo_base = {12'hB00, 12'hA00, 12'h900, 12'h800};
    tx_fifo_size = {4{12'h040}};
    codes = '{usb_host_ep_pkg::RES_ERR, usb_host_ep_pkg::RES_STALL, usb_host_ep_pkg::RES_NAK};
    ntok = '{3, 1, 2};
    repeat (20) @(negedge core_clk);
    rstn = 1'b1;
    check("reset flags", {request_packet_flag, receive_packet_ready, transmit_packet_ready, auto_request}, 0);
    check("reset ready", rx_in_ready, 1);
    t0 = toks;
    r0 = rirqs;
    strobe(0, 1);
    wait_quiet();
    check("in tokens", toks - t0, 1);
    check("in token", tok_snap, {1'b1, 2'h1, 7'h11, 4'h2, 2'h2, 1'b1});
    check("in fifo", fifo_snap, {12'h200, 12'h080});
    check("rx ready", {receive_packet_ready[1], request_packet_flag[1]}, 2'b10);
    check("rx irq", rirqs - r0, 1);
    a0 = acks;
    strobe(1, 1);
    wait_quiet();
    check("ack count", acks - a0, 1);
    check("ack if", {ack_snap, receive_packet_ready[1]}, 3'b010);
    strobe(0, 0);
    wait_quiet();
    check("ctrl token", tok_snap, {1'b1, 2'h0, 7'h10, 4'h0, 2'h0, 1'b0});
    check("ctrl fifo", fifo_snap, {12'h000, 12'h040});
    strobe(1, 0);
    wait_quiet();
    // receiver stalls while two counted auto requests run
    auto_clear_rx = 4'h2;
    cnt_value = 16'h0002;
    rd_ready = 1'b0;
    t0 = toks;
    a0 = acks;
    strobe(6, 1);
    strobe(3, 1);
    strobe(0, 1);
    repeat (20) @(negedge core_clk);
    check("buffer stall", {rx_in_ready, rd_valid}, 2'b01);
    rd_ready = 1'b1;
    wait_quiet();
    check("auto tokens", toks - t0, 2);
    check("auto clears", acks - a0, 2);
    check("auto state", {auto_request[1], receive_packet_ready[1], request_packet_flag[1]}, 0);
    auto_clear_rx = 4'h0;
    t0 = toks;
    strobe(3, 2);
    strobe(0, 2);
    wait_quiet();
    check("areq kept", auto_request[2], 1);
    reply_len = 11'h002;
    strobe(1, 2);
    wait_quiet();
    check("short packet", {auto_request[2], receive_packet_ready[2]}, 2'b01);
    strobe(1, 2);
    wait_quiet();
    check("short tokens", toks - t0, 2);
    check("no rerequest", request_packet_flag[2], 0);
    strobe(3, 0);
    strobe(4, 0);
    check("areq cleared", auto_request[0], 0);
    reply_len = 11'h004;
    r0 = tirqs;
    strobe(2, 2);
    wait_quiet();
    check("out token", tok_snap, {1'b0, 2'h2, 7'h22, 4'h5, 2'h3, 1'b0});
    check("out fifo", fifo_snap, {12'hA00, 12'h040});
    check("tx done", {transmit_packet_ready[2], 4'(tirqs - r0)}, 5'h01);
    auto_set_tx = 4'h2;
    t0 = toks;
    for (i = 0; i < 4; i++) strobe(7, 1);
    wait_quiet();
    check("auto set tokens", toks - t0, 1);
    check("auto set dir", tok_snap[16:14], 3'b001);
    for (d = 0; d < 2; d++) begin
      for (c = 0; c < 3; c++) begin
        reply = codes[c];
        t0 = toks;
        r0 = rirqs + tirqs;
        f0 = flushes;
        strobe(d * 2, 3);
        wait_quiet();
        flags = d ? {tx_error[3], tx_stalled[3], tx_nak_timeout[3]} : {rx_error[3], rx_stalled[3], rx_nak_timeout[3]};
        check("fault tokens", toks - t0, ntok[c]);
        check("fault flag", flags, 3'b100 >> c);
        check("pending cleared", d ? transmit_packet_ready[3] : request_packet_flag[3], 0);
        check("fault irq", rirqs + tirqs - r0, 1);
        check("flush", flushes - f0, (d == 1 && c == 0));
        strobe(5, 3);
      end
    end
    check("status cleared", {rx_error, rx_stalled, rx_nak_timeout, tx_error, tx_stalled, tx_nak_timeout}, 0);
    conclude();
  end
endmodule
`default_nettype wire
